// File: logic/aec_defines.svh
`ifndef AEC_DEFINES_SVH
`define AEC_DEFINES_SVH
// Status byte classes
`define AEC_CLS_REJECT 8'h40
`define AEC_CLS_SPEC 8'h10
`define AEC_CLS_DEVICE 8'h80
`define AEC_CLS_NONE 8'h00
// Error numbers
`define AEC_E_SST_ADDR 8'h23
`define AEC_E_SST_INFLAG 8'h25
`define AEC_E_SST_ODDCNT 8'h26
`define AEC_E_SST_BIGCNT 8'h27
`define AEC_E_SST_ODDADR 8'h28
`define AEC_E_IF_ONES 8'h2A
`define AEC_E_IF_ZEROS 8'h2B
`define AEC_E_IF_FORM 8'h2C
`define AEC_E_FEATURE 8'h2D
`define AEC_E_POR_NRDY 8'h2E
`define AEC_E_POR_OK 8'h2F
`define AEC_E_POR_OFFCYL 8'h30
`define AEC_E_SEEK_TMO 8'h31
`define AEC_E_OUT_PAR 8'h32
`define AEC_E_IF2_ZEROS 8'h34
`define AEC_E_IF2_ONES 8'h35
`define AEC_E_BUS_PAR 8'h36
`define AEC_E_RD_SYNC 8'h38
`define AEC_E_RD_IDSYNC 8'h39
`define AEC_E_BC_ODDCNT 8'h40
`define AEC_E_BC_ODDADR 8'h41
`define AEC_E_ST_MOD 8'h42
`define AEC_E_ST_INFLAG 8'h43
`define AEC_E_ST_NRDY 8'h44
// Field positions and limits
`define AEC_INFLAG_BIT 13
`define AEC_SST_MAX_CNT 16'h0018
`define AEC_IF_ONES 8'hFF
`define AEC_IF_ZEROS 8'h00
// Seek timeout
`define AEC_CLK_HZ 10000000
`define AEC_SEEK_TMO_MS 130
`define AEC_SEEK_TMO_CYC ((`AEC_CLK_HZ / 1000) * `AEC_SEEK_TMO_MS)
`endif

// File: logic/aec_pkg.sv
package aec_pkg;
	// Checker states
	typedef enum logic [1:0] {
		AEC_IDLE = 2'b00,
		AEC_SEEK = 2'b01,
		AEC_DONE = 2'b10
	} aec_state_t;
	// Whole block state
	typedef struct packed {
		aec_state_t st;
		logic [20:0] seek_cnt;
		logic [7:0] err;
		logic [7:0] cls;
		logic done;
	} aec_regs_t;
endpackage

// File: logic/aec_sync2.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bus of pin levels
module aec_sync2 #(
	parameter int W = 8
) (
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Sync reset
	input wire logic [W-1:0] d_i, // Async pins
	output logic [W-1:0] q_o // Synchronised
);
	logic [W-1:0] meta_q; // First stage, read only by second
	// Plain double register
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			meta_q <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// File: logic/aec_classifier.sv
`timescale 1ns/1ps
`include "aec_defines.svh"
module aec_classifier (
	input wire logic clk_i, // 10 MHz clock
	input wire logic srst_i, // Sync reset, active high
	input wire logic sst_imm_i, // Status-transfer immediate command pulse
	input wire logic [15:0] sst_imm_addr_i, // Block address from modifier field
	input wire logic sst_blk_i, // Status-transfer block fetched pulse
	input wire logic st_blk_i, // Start-transfer block fetched pulse
	input wire logic [15:0] blk_w0_i, // Block word 0
	input wire logic [15:0] blk_w6_i, // Block word 6, byte count
	input wire logic [15:0] blk_w7_i, // Block word 7, data address
	input wire logic byte_cnt_i, // Block is of byte-counting kind
	input wire logic mod_ok_i, // Modifier is permitted
	input wire logic mod_wants_in_i, // Modifier needs input flag set
	input wire logic if_chk_i, // First interface check pulse
	input wire logic if_chk2_i, // Second interface check pulse
	input wire logic [7:0] drv_bus_i, // Drive interface lines, async
	input wire logic form_bad_i, // Drive info not of expected form
	input wire logic feat_bad_i, // Feature id not permitted
	input wire logic por_chk_i, // Power-on state sample pulse
	input wire logic drv_ready_i, // Drive ready, async
	input wire logic drv_oncyl_i, // Drive on cylinder, async
	input wire logic seek_start_i, // Seek issued pulse
	input wire logic seek_end_i, // Seek-end or seek-error interrupt
	input wire logic out_par_err_i, // Outbound parity error pulse
	input wire logic bus_par_err_i, // Bus-in/out parity suspect pulse
	input wire logic rd_diag_i, // Read diagnostic in progress
	input wire logic rd_sync_err_i, // Sync or correction error pulse
	input wire logic rd_id_err_i, // Id sync or id CRC error pulse
	input wire logic status_ack_i, // Host took status, clears it
	output logic done_o, // Status ready, level
	output logic [15:0] status_w3_o, // Status block word 3
	output logic [7:0] completion_status_byte_o // Completion class byte
);
	aec_pkg::aec_regs_t r_q; // All registered state
	aec_pkg::aec_regs_t r_d; // Next state
	logic [7:0] bus_s; // Synchronised drive lines
	logic [1:0] st_s; // Synchronised ready/on cylinder
	logic [7:0] ev_err; // Error picked this cycle
	logic [7:0] ev_cls; // Class picked this cycle
	logic ev; // Some error this cycle

	// Drive pins cross from the cable, so double register them
	aec_sync2 #(
		.W(10)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i({drv_oncyl_i, drv_ready_i, drv_bus_i}),
		.q_o({st_s, bus_s})
	);

	// Odd test shared by counts and addresses
	function automatic logic is_odd(input logic [15:0] v);
		is_odd = v[0];
	endfunction

	// Priority picker; first hit in each group wins
	always_comb
	begin
		ev = 1'b0;
		ev_err = `AEC_CLS_NONE;
		ev_cls = `AEC_CLS_NONE;
		if (sst_imm_i && is_odd(sst_imm_addr_i))
		begin
			ev = 1'b1;
			ev_err = `AEC_E_SST_ADDR;
			ev_cls = `AEC_CLS_REJECT;
		end
		else if (sst_blk_i)
		begin
			// Status-transfer block checks
			ev_cls = `AEC_CLS_SPEC;
			ev = 1'b1;
			if (!blk_w0_i[`AEC_INFLAG_BIT])
				ev_err = `AEC_E_SST_INFLAG;
			else if (is_odd(blk_w6_i))
				ev_err = `AEC_E_SST_ODDCNT;
			else if (blk_w6_i > `AEC_SST_MAX_CNT)
				ev_err = `AEC_E_SST_BIGCNT;
			else if (is_odd(blk_w7_i))
				ev_err = `AEC_E_SST_ODDADR;
			else
			begin
				ev = 1'b0;
				ev_cls = `AEC_CLS_NONE;
			end
		end
		else if (st_blk_i)
		begin
			// Start-transfer block checks, then drive state
			ev = 1'b1;
			ev_cls = `AEC_CLS_SPEC;
			if (!mod_ok_i)
				ev_err = `AEC_E_ST_MOD;
			else if (blk_w0_i[`AEC_INFLAG_BIT] != mod_wants_in_i)
				ev_err = `AEC_E_ST_INFLAG;
			else if (byte_cnt_i && is_odd(blk_w6_i))
				ev_err = `AEC_E_BC_ODDCNT;
			else if (byte_cnt_i && is_odd(blk_w7_i))
				ev_err = `AEC_E_BC_ODDADR;
			else if (st_s != 2'b11)
			begin
				ev_err = `AEC_E_ST_NRDY;
				ev_cls = `AEC_CLS_DEVICE;
			end
			else
			begin
				ev = 1'b0;
				ev_cls = `AEC_CLS_NONE;
			end
		end
		// A block that passes its checks must not hide a drive fault or a seek expiry
		if (!ev)
		begin
			// Drive side faults, all device status class
			ev = 1'b1;
			ev_cls = `AEC_CLS_DEVICE;
			if (if_chk_i && bus_s == `AEC_IF_ONES)
				ev_err = `AEC_E_IF_ONES;
			else if (if_chk_i && bus_s == `AEC_IF_ZEROS)
				ev_err = `AEC_E_IF_ZEROS;
			else if (if_chk2_i && bus_s == `AEC_IF_ZEROS)
				ev_err = `AEC_E_IF2_ZEROS;
			else if (if_chk2_i && bus_s == `AEC_IF_ONES)
				ev_err = `AEC_E_IF2_ONES;
			else if (form_bad_i)
				ev_err = `AEC_E_IF_FORM;
			else if (feat_bad_i)
				ev_err = `AEC_E_FEATURE;
			else if (por_chk_i && st_s == 2'b00)
				ev_err = `AEC_E_POR_NRDY;
			else if (por_chk_i && st_s == 2'b11)
				ev_err = `AEC_E_POR_OK;
			else if (por_chk_i && st_s == 2'b01)
				ev_err = `AEC_E_POR_OFFCYL;
			else if (r_q.st == aec_pkg::AEC_SEEK && !seek_end_i
				&& r_q.seek_cnt == 21'(`AEC_SEEK_TMO_CYC - 1))
				ev_err = `AEC_E_SEEK_TMO;
			else if (out_par_err_i)
				ev_err = `AEC_E_OUT_PAR;
			else if (bus_par_err_i)
				ev_err = `AEC_E_BUS_PAR;
			else if (rd_diag_i && rd_sync_err_i)
				ev_err = `AEC_E_RD_SYNC;
			else if (rd_diag_i && rd_id_err_i)
				ev_err = `AEC_E_RD_IDSYNC;
			else
			begin
				ev = 1'b0;
				ev_cls = `AEC_CLS_NONE;
			end
		end
	end

	// Next-state logic: seek timer and status latch
	always_comb
	begin
		r_d = r_q;
		case (r_q.st)
			aec_pkg::AEC_IDLE:
			begin
				// Timer idle until a seek is issued
				r_d.seek_cnt = '0;
				if (seek_start_i)
					r_d.st = aec_pkg::AEC_SEEK;
			end
			aec_pkg::AEC_SEEK:
			begin
				// Interrupt stops the timer; expiry is caught by picker
				r_d.seek_cnt = r_q.seek_cnt + 21'd1;
				if (seek_end_i)
					r_d.st = aec_pkg::AEC_IDLE;
				else if (r_q.seek_cnt == 21'(`AEC_SEEK_TMO_CYC - 1))
					r_d.st = aec_pkg::AEC_DONE;
			end
			default:
			begin
				// Timed out; wait for a new seek
				r_d.seek_cnt = '0;
				if (seek_start_i)
					r_d.st = aec_pkg::AEC_SEEK;
			end
		endcase
		// First error held until host takes it; a new error wins over ack
		if (ev && (!r_q.done || status_ack_i))
		begin
			r_d.err = ev_err;
			r_d.cls = ev_cls;
			r_d.done = 1'b1;
		end
		else if (status_ack_i)
		begin
			r_d.done = 1'b0;
			r_d.err = `AEC_CLS_NONE;
			r_d.cls = `AEC_CLS_NONE;
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			r_q <= '{st: aec_pkg::AEC_IDLE, seek_cnt: '0, err: '0, cls: '0, done: 1'b0};
		else
			r_q <= r_d;
	end

	// Outputs straight from registers
	assign done_o = r_q.done;
	assign status_w3_o = {8'h00, r_q.err};
	assign completion_status_byte_o = r_q.cls;
endmodule

// File: tb/aec_smd_model.sv
`timescale 1ns/1ps
// Drive side of the attachment, as seen on its lines
module aec_smd_model (
	input wire logic pwr_i, // Drive powered
	input wire logic cab_i, // Cable intact
	input wire logic rdy_i, // Ready wish
	input wire logic cyl_i, // On-cylinder wish
	output logic [7:0] bus_o, // Interface lines
	output logic rdy_o, // Ready line
	output logic cyl_o // On-cylinder line
);
	// Unpowered lines float high, a cut cable reads low
	always_comb
	begin
		bus_o = !pwr_i ? 8'hFF : (!cab_i ? 8'h00 : 8'h5A);
		rdy_o = pwr_i & cab_i & rdy_i;
		cyl_o = pwr_i & cab_i & cyl_i;
	end
endmodule

// File: tb/aec_monitor.sv
`timescale 1ns/1ps
module aec_monitor (
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic sst_imm_i, // Immediate
	input wire logic [15:0] sst_imm_addr_i, // Block address
	input wire logic sst_blk_i, // Status block
	input wire logic st_blk_i, // Start block
	input wire logic [15:0] blk_w0_i, // Word 0
	input wire logic [15:0] blk_w6_i, // Word 6
	input wire logic [15:0] blk_w7_i, // Word 7
	input wire logic byte_cnt_i, // Byte counting
	input wire logic mod_ok_i, // Modifier ok
	input wire logic mod_wants_in_i, // Flag wanted
	input wire logic if_chk_i, // Check one
	input wire logic if_chk2_i, // Check two
	input wire logic form_bad_i, // Bad form
	input wire logic feat_bad_i, // Bad feature
	input wire logic por_chk_i, // Power-on
	input wire logic out_par_err_i, // Parity
	input wire logic status_ack_i, // Ack
	input wire logic done_o, // Done
	input wire logic [15:0] status_w3_o, // Word 3
	input wire logic [7:0] completion_status_byte_o // Class
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Higher-priority events that would mask a parity report
	wire hi = sst_imm_i | sst_blk_i | st_blk_i | if_chk_i | if_chk2_i | form_bad_i
		| feat_bad_i | por_chk_i;
	odd_addr_a: assert property (sst_imm_i && sst_imm_addr_i[0] && !done_o |=>
		status_w3_o == 16'h0023 && completion_status_byte_o == 8'h40) else $error("odd addr");
	in_flag_a: assert property (sst_blk_i && !sst_imm_i && !blk_w0_i[13] && !done_o |=>
		done_o && completion_status_byte_o == 8'h10) else $error("input flag");
	big_cnt_a: assert property (sst_blk_i && !sst_imm_i && !done_o && blk_w0_i[13]
		&& !blk_w6_i[0] && !blk_w7_i[0] && blk_w6_i > 16'h0018 |=> status_w3_o == 16'h0027)
		else $error("big count");
	spec_cls_a: assert property (done_o && status_w3_o inside {[16'h0025:16'h0028],
		[16'h0040:16'h0043]} |-> completion_status_byte_o == 8'h10) else $error("spec class");
	dev_cls_a: assert property (done_o && status_w3_o inside {[16'h002A:16'h0039],
		16'h0044} |-> completion_status_byte_o == 8'h80) else $error("device class");
	status_held_a: assert property (done_o && !status_ack_i |=> done_o
		&& $stable(status_w3_o)) else $error("status not held");
	out_par_a: assert property (out_par_err_i && !hi && !done_o |=>
		status_w3_o == 16'h0032) else $error("parity");
	flag_mod_a: assert property (st_blk_i && !sst_imm_i && !sst_blk_i && !byte_cnt_i
		&& mod_ok_i && blk_w0_i[13] != mod_wants_in_i && !done_o |=> status_w3_o == 16'h0043)
		else $error("flag phase");
	cover property (done_o && completion_status_byte_o == 8'h40);
	cover property (done_o && status_w3_o == 16'h0044);
	cover property (done_o && status_ack_i);
endmodule
bind aec_classifier aec_monitor mon (.*);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_i = 0; // 10 MHz clock
	logic srst_i = 1; // Sync reset
	logic [11:0] ev = 0; // Event pulses, one-hot in the rows; hand tests set two at once
	logic [11:0] evr; // Row event
	logic [15:0] w0 = 0, w6 = 0, w7 = 0; // Block words
	logic [3:0] ctl = 0; // Diag, byte count, mod ok, wants
	logic [3:0] drv = 4'hF; // Power, cable, ready, cylinder
	logic seek_s = 0, seek_e = 0, ack = 0; // Seek and ack
	logic [7:0] bus; // Drive lines
	logic rdy, cyl; // Drive state
	logic done_o; // Status ready
	logic [15:0] w3, ex; // Word 3, expected error and class
	logic [7:0] csb; // Class byte
	int err_count = 0; // Mismatches
	int cmp_count = 0; // Comparisons
	int cyc = 0; // Watchdog
	// Rows: event, word 0, count, address, ctl, drive, error, class
	logic [67:0] rows [23] = '{68'h001_0001_00_00_0_F_23_40, 68'h002_0000_02_02_0_F_25_10,
		68'h002_2000_03_02_0_F_26_10, 68'h002_2000_1A_02_0_F_27_10,
		68'h002_2000_18_03_0_F_28_10, 68'h008_0000_00_00_0_7_2A_80,
		68'h008_0000_00_00_0_B_2B_80, 68'h010_0000_00_00_0_B_34_80,
		68'h010_0000_00_00_0_7_35_80, 68'h020_0000_00_00_0_F_2C_80,
		68'h040_0000_00_00_0_F_2D_80, 68'h080_0000_00_00_0_C_2E_80,
		68'h080_0000_00_00_0_F_2F_80, 68'h080_0000_00_00_0_E_30_80,
		68'h100_0000_00_00_0_F_32_80, 68'h200_0000_00_00_0_F_36_80,
		68'h400_0000_00_00_8_F_38_80, 68'h800_0000_00_00_8_F_39_80,
		68'h004_2000_03_02_7_F_40_10, 68'h004_2000_02_03_7_F_41_10,
		68'h004_2000_02_02_1_F_42_10, 68'h004_0000_02_02_3_F_43_10,
		68'h004_2000_02_02_3_D_44_80};
	always #50 clk_i = ~clk_i;
	aec_smd_model drv_m (.pwr_i(drv[3]), .cab_i(drv[2]), .rdy_i(drv[1]), .cyl_i(drv[0]),
		.bus_o(bus), .rdy_o(rdy), .cyl_o(cyl));
	aec_classifier dut (.clk_i, .srst_i, .sst_imm_i(ev[0]), .sst_imm_addr_i(w0),
		.sst_blk_i(ev[1]), .st_blk_i(ev[2]), .blk_w0_i(w0), .blk_w6_i(w6), .blk_w7_i(w7),
		.byte_cnt_i(ctl[2]), .mod_ok_i(ctl[1]), .mod_wants_in_i(ctl[0]), .if_chk_i(ev[3]),
		.if_chk2_i(ev[4]), .drv_bus_i(bus), .form_bad_i(ev[5]), .feat_bad_i(ev[6]),
		.por_chk_i(ev[7]), .drv_ready_i(rdy), .drv_oncyl_i(cyl), .seek_start_i(seek_s),
		.seek_end_i(seek_e), .out_par_err_i(ev[8]), .bus_par_err_i(ev[9]),
		.rd_diag_i(ctl[3]), .rd_sync_err_i(ev[10]), .rd_id_err_i(ev[11]),
		.status_ack_i(ack), .done_o, .status_w3_o(w3), .completion_status_byte_o(csb));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Edges, then settle off the sampling edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse_ack;
		ack = 1;
		tick(1);
		ack = 0;
		chk({15'h0000, done_o}, 16'h0000);
		tick(1);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog well above the roughly 180 cycles needed
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			err_count++;
			tally_and_finish;
		end
	end
	initial
	begin
		tick(8);
		chk(w3, 16'h0000);
		chk({done_o, csb}, 16'h0000);
		srst_i = 0;
		tick(1);
		// Three edges let drive lines cross the synchroniser
		foreach (rows[i])
		begin
			{evr, w0, w6[7:0], w7[7:0], ctl, drv, ex} = rows[i];
			tick(3);
			ev = evr;
			tick(1);
			ev = 0;
			chk(w3, {8'h00, ex[15:8]});
			chk({7'h00, done_o, csb}, {8'h01, ex[7:0]});
			pulse_ack;
			$display("row %0d done", i);
		end
		// Priority, then a drop while status is held
		w0 = 16'h0001;
		ev = 12'h101;
		tick(1);
		ev = 12'h100;
		tick(1);
		ev = 0;
		chk(w3, 16'h0023);
		// Ack beside a new error keeps the new one
		ack = 1;
		ev = 12'h200;
		tick(1);
		ack = 0;
		ev = 0;
		chk(w3, 16'h0036);
		pulse_ack;
		// Seek answered in time raises nothing
		seek_s = 1;
		tick(1);
		seek_s = 0;
		tick(20);
		seek_e = 1;
		tick(1);
		seek_e = 0;
		tick(2);
		chk({15'h0000, done_o}, 16'h0000);
		// A clean start block beside a parity pulse still reports the parity
		w0 = 16'h2000;
		drv = 4'hF;
		tick(3);
		ev = 12'h104;
		tick(1);
		ev = 0;
		chk(w3, 16'h0032);
		pulse_ack;
		$display("hand tests done");
		tally_and_finish;
	end
endmodule
